// ===== verilog/fdl_top.sv
// The strobed register port was left to the implementer.
`default_nettype none

module fdl_top
  import fdl_pkg::*;
#(
  parameter logic [5:0] DET_REPS0 = 6'h03,
  parameter logic [5:0] DET_REPS1 = 6'h05,
  parameter logic [5:0] DET_REPS2 = 6'h07,
  parameter logic [5:0] DET_REPS3 = 6'h0A,
  parameter logic [5:0] DIS_REPS0 = 6'h03,
  parameter logic [5:0] DIS_REPS1 = 6'h05,
  parameter logic [5:0] DIS_REPS2 = 6'h07,
  parameter logic [5:0] DIS_REPS3 = 6'h0A
) (
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [7:0]        wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output var  logic [7:0]        rdata,
  input  wire logic              esf_mode,
  input  wire fdl_rx_in_t        rx_in,
  input  wire logic              tx_slot,
  output var  fdl_tx_out_t       tx_out,
  output var  logic              interrupt_out_n
);

  // ==========================================================================
  // Registers and state.
  logic [7:0]  rx_code_control_r;
  logic [7:0]  rx_link_byte_r;
  logic [5:0]  rx_code_value_r;
  logic [7:0]  rx_latched_status_seven_r;
  logic [7:0]  rx_interrupt_mask_seven_r;
  logic [7:0]  tx_link_byte_r;
  logic [7:0]  tx_control_two_r;
  logic [7:0]  tx_latched_status_two_r;
  logic [7:0]  tx_interrupt_mask_two_r;
  logic [7:0]  tx_cur_r;
  logic [2:0]  tx_idx_r;
  logic [7:0]  rx_sh_r;
  logic [2:0]  rx_cnt_r;
  logic [15:0] win_r;
  logic [5:0]  cand_r;
  logic [5:0]  rep_r;
  logic [3:0]  slot_r;
  logic [5:0]  miss_r;
  fdl_boc_st_t boc_st_r;

  // Picks one of four thresholds with a two-bit selector.
  function automatic logic [5:0] pick_reps(input logic [1:0] sel,
                                           input logic [5:0] a,
                                           input logic [5:0] b,
                                           input logic [5:0] c,
                                           input logic [5:0] d);
    logic [5:0] v;
    v = a;
    if (sel == 2'h1) begin
      v = b;
    end else if (sel == 2'h2) begin
      v = c;
    end else if (sel == 2'h3) begin
      v = d;
    end
    return v;
  endfunction

  // ==========================================================================
  // Bus decode.
  logic wr_code_ctl, wr_st7, wr_mask7, wr_tx_link, wr_ctl2;
  logic wr_st2, wr_mask2;
  assign wr_code_ctl = wr && (addr == OFS_RX_CODE_CTL);
  assign wr_st7      = wr && (addr == OFS_RX_STAT7);
  assign wr_mask7    = wr && (addr == OFS_RX_MASK7);
  assign wr_tx_link  = wr && (addr == OFS_TX_LINK);
  assign wr_ctl2     = wr && (addr == OFS_TX_CTL2);
  assign wr_st2      = wr && (addr == OFS_TX_STAT2);
  assign wr_mask2    = wr && (addr == OFS_TX_MASK2);

  // Read data stand for the one cycle after the strobe, zero otherwise.
  always_ff @(posedge mclk) begin
    if (rst || !rd) begin
      rdata <= RST_BYTE;
    end else if (addr == OFS_RX_CODE_CTL) begin
      rdata <= rx_code_control_r;
    end else if (addr == OFS_RX_LINK) begin
      rdata <= rx_link_byte_r;
    end else if (addr == OFS_RX_CODE_VAL) begin
      rdata <= {2'h0, rx_code_value_r};
    end else if (addr == OFS_RX_STAT7) begin
      rdata <= rx_latched_status_seven_r;
    end else if (addr == OFS_RX_MASK7) begin
      rdata <= rx_interrupt_mask_seven_r;
    end else if (addr == OFS_TX_LINK) begin
      rdata <= tx_link_byte_r;
    end else if (addr == OFS_TX_CTL2) begin
      rdata <= tx_control_two_r;
    end else if (addr == OFS_TX_STAT2) begin
      rdata <= tx_latched_status_two_r;
    end else if (addr == OFS_TX_MASK2) begin
      rdata <= tx_interrupt_mask_two_r;
    end else begin
      rdata <= RST_BYTE;
    end
  end

  // Plain read/write control registers.
  always_ff @(posedge mclk) begin
    if (rst) begin
      rx_code_control_r         <= RST_BYTE;
      rx_interrupt_mask_seven_r <= RST_BYTE;
      tx_link_byte_r            <= RST_BYTE;
      tx_control_two_r          <= RST_BYTE;
      tx_interrupt_mask_two_r   <= RST_BYTE;
    end else begin
      if (wr_code_ctl) begin
        rx_code_control_r <= wdata;
      end
      if (wr_mask7) begin
        rx_interrupt_mask_seven_r <= wdata;
      end
      if (wr_tx_link) begin
        tx_link_byte_r <= wdata;
      end
      if (wr_ctl2) begin
        tx_control_two_r <= wdata;
      end
      if (wr_mask2) begin
        tx_interrupt_mask_two_r <= wdata;
      end
    end
  end

  // ==========================================================================
  // Code detector: a codeword is eight ones, a zero, six code bits first bit
  // lowest, then a zero; oldest bit sits in the low end of the window.
  logic [15:0] win_nxt;
  logic        code_bit;
  logic        match;
  logic [5:0]  code;
  logic [5:0]  rep_nxt;
  logic [5:0]  det_thr;
  logic [5:0]  dis_thr;
  logic        det_ev;
  logic        clr_ev;

  assign code_bit = rx_in.bit_stb && esf_mode;
  assign win_nxt  = {rx_in.bit_val, win_r[15:1]};
  assign match    = code_bit && (win_nxt[7:0] == 8'hFF) && !win_nxt[8]
                    && !win_nxt[15];
  assign code     = win_nxt[14:9];
  assign det_thr  = pick_reps(rx_code_control_r[CC_FILT_LSB +: 2],
                              DET_REPS0, DET_REPS1,
                              DET_REPS2, DET_REPS3);
  assign dis_thr  = pick_reps(rx_code_control_r[CC_DIS_LSB +: 2],
                              DIS_REPS0, DIS_REPS1,
                              DIS_REPS2, DIS_REPS3);

  // Repetition count of the current candidate, saturating.
  always_comb begin
    rep_nxt = 6'h01;
    if (code == cand_r && rep_r != 6'h00) begin
      rep_nxt = (rep_r == REP_MAX) ? REP_MAX : rep_r + 6'h01;
    end
  end

  // A held code only fires again when it changes; after a clear it may fire.
  assign det_ev = match && (rep_nxt >= det_thr)
                  && (boc_st_r == BOC_IDLE || code != rx_code_value_r);
  assign clr_ev = code_bit && !match && boc_st_r == BOC_HELD
                  && slot_r == CODE_SLOT_LAST
                  && (miss_r + 6'h01 >= dis_thr);

  // Window, candidate and miss counters advance on each data link bit in extended superframe mode.
  always_ff @(posedge mclk) begin
    if (rst) begin
      win_r  <= 16'h0000;
      cand_r <= 6'h00;
      rep_r  <= 6'h00;
      slot_r <= 4'h0;
      miss_r <= 6'h00;
    end else if (code_bit) begin
      win_r <= win_nxt;
      if (match) begin
        cand_r <= code;
        rep_r  <= rep_nxt;
        slot_r <= 4'h0;
        miss_r <= 6'h00;
      end else if (slot_r == CODE_SLOT_LAST) begin
        slot_r <= 4'h0;
        miss_r <= (miss_r == REP_MAX) ? REP_MAX : miss_r + 6'h01;
        if (clr_ev) begin
          rep_r <= 6'h00;
        end
      end else begin
        slot_r <= slot_r + 4'h1;
      end
    end
  end

  // Detector state and the reported code.
  always_ff @(posedge mclk) begin
    if (rst) begin
      boc_st_r        <= BOC_IDLE;
      rx_code_value_r <= 6'h00;
    end else begin
      case (boc_st_r)
        BOC_IDLE: begin
          if (det_ev) begin
            boc_st_r        <= BOC_HELD;
            rx_code_value_r <= code;
          end
        end
        BOC_HELD: begin
          if (det_ev) begin
            rx_code_value_r <= code;
          end else if (clr_ev) begin
            boc_st_r <= BOC_IDLE;
          end
        end
        default: begin
          boc_st_r <= BOC_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Receive data link byte: bits enter at the top and move down, so the
  // first bit received ends in bit 0; no destuffing is done.
  logic rx_fill;
  logic rx_d4_upd;
  assign rx_fill   = esf_mode && rx_in.bit_stb && rx_cnt_r == RX_LAST_BIT;
  assign rx_d4_upd = !esf_mode && rx_in.mf_bound;

  always_ff @(posedge mclk) begin
    if (rst) begin
      rx_sh_r        <= RST_BYTE;
      rx_cnt_r       <= 3'h0;
      rx_link_byte_r <= RST_BYTE;
    end else begin
      if (rx_in.bit_stb) begin
        rx_sh_r  <= {rx_in.bit_val, rx_sh_r[7:1]};
        rx_cnt_r <= rx_cnt_r + 3'h1;
      end
      if (rx_fill) begin
        rx_link_byte_r <= {rx_in.bit_val, rx_sh_r[7:1]};
      end else if (rx_d4_upd) begin
        rx_link_byte_r <= {2'h0, rx_sh_r[7:2]};
        rx_cnt_r       <= 3'h0;
      end
    end
  end

  // ==========================================================================
  // Transmit serialiser: the held byte is copied at each byte boundary,
  // so an unwritten register is simply sent again; no stuffing is added.
  logic       tx_sel_reg;
  logic [2:0] tx_last;
  logic       tx_end;
  assign tx_sel_reg = !tx_control_two_r[CTL2_SRC];
  assign tx_last    = esf_mode ? TX_LAST_ESF : TX_LAST_D4;
  assign tx_end     = tx_slot && tx_sel_reg && tx_idx_r >= tx_last;

  always_ff @(posedge mclk) begin
    if (rst) begin
      tx_cur_r <= RST_BYTE;
      tx_idx_r <= 3'h0;
      tx_out   <= '0;
    end else begin
      tx_out.from_reg <= tx_sel_reg;
      if (tx_slot && tx_sel_reg) begin
        tx_out.bit_val <= tx_cur_r[tx_idx_r];
        if (tx_end) begin
          tx_idx_r <= 3'h0;
          tx_cur_r <= tx_link_byte_r;
        end else begin
          tx_idx_r <= tx_idx_r + 3'h1;
        end
      end
    end
  end

  // ==========================================================================
  // Latched status: a hardware set wins over a write-one clear.
  always_ff @(posedge mclk) begin
    if (rst) begin
      rx_latched_status_seven_r <= RST_BYTE;
      tx_latched_status_two_r   <= RST_BYTE;
    end else begin
      rx_latched_status_seven_r[ST7_DETECT] <= det_ev
        || (rx_latched_status_seven_r[ST7_DETECT]
            && !(wr_st7 && wdata[ST7_DETECT]));
      rx_latched_status_seven_r[ST7_CLEAR] <= clr_ev
        || (rx_latched_status_seven_r[ST7_CLEAR]
            && !(wr_st7 && wdata[ST7_CLEAR]));
      rx_latched_status_seven_r[ST7_FULL] <= rx_fill || rx_d4_upd
        || (rx_latched_status_seven_r[ST7_FULL]
            && !(wr_st7 && wdata[ST7_FULL]));
      tx_latched_status_two_r[ST2_EMPTY] <= tx_end
        || (tx_latched_status_two_r[ST2_EMPTY]
            && !(wr_st2 && wdata[ST2_EMPTY]));
    end
  end

  // Active-low interrupt from masked latched flags.
  always_ff @(posedge mclk) begin
    if (rst) begin
      interrupt_out_n <= 1'b1;
    end else begin
      interrupt_out_n <= !(|(rx_latched_status_seven_r[2:0]
                             & rx_interrupt_mask_seven_r[2:0])
                           || (tx_latched_status_two_r[ST2_EMPTY]
                               && tx_interrupt_mask_two_r[ST2_EMPTY]));
    end
  end

  // ==========================================================================
  // Checks.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence tx_byte_done_s;
    tx_slot && !tx_control_two_r[CTL2_SRC] && tx_idx_r >= tx_last;
  endsequence

  irq_gating_a: assert property (
    ((rx_latched_status_seven_r[2:0] & rx_interrupt_mask_seven_r[2:0])
     == 3'h0 && !(tx_latched_status_two_r[4] && tx_interrupt_mask_two_r[4]))
    |=> interrupt_out_n)
    else $error("interrupt raised with no unmasked flag");

  esf_only_a: assert property (!esf_mode |-> !det_ev && !clr_ev)
    else $error("code event outside extended superframe mode");

  detect_flag_a: assert property (
    det_ev |=> rx_latched_status_seven_r[0]
               && rx_code_value_r == $past(code))
    else $error("detect did not latch flag and code");

  held_quiet_a: assert property (
    boc_st_r == BOC_HELD && match && code == rx_code_value_r |-> !det_ev)
    else $error("held code detected again");

  clear_flag_a: assert property (
    clr_ev |=> rx_latched_status_seven_r[1] && boc_st_r == BOC_IDLE)
    else $error("clear event not reported");

  tx_empty_a: assert property (
    tx_byte_done_s |=> tx_latched_status_two_r[4]
                       && tx_cur_r == $past(tx_link_byte_r) && tx_idx_r == 0)
    else $error("byte end without empty flag or reload");

  rx_full_a: assert property (
    rx_fill |=> rx_latched_status_seven_r[2]
                && rx_link_byte_r[7] == $past(rx_in.bit_val))
    else $error("receive byte not captured");

  d4_update_a: assert property (
    !esf_mode && !rx_in.mf_bound && !rx_fill |=> $stable(rx_link_byte_r))
    else $error("superframe receive byte changed off boundary");

  d4_six_a: assert property (
    tx_slot && tx_sel_reg && !esf_mode |=> tx_idx_r <= TX_LAST_D4)
    else $error("transmit index passed the six-bit limit");

  read_idle_a: assert property (!rd |=> rdata == RST_BYTE)
    else $error("read data shown without a read strobe");

endmodule

`default_nettype wire

// ===== verilog/fdl_pkg.sv
// Behaviour
// - Code detector runs only in extended superframe mode.
// - Data link bits watched continuously for codes.
// - Detect flag sets after filter-selected persistence.
// - Detected six-bit code readable by host.
// - Cleared detect stays clear until new code.
// - Clear flag sets after disintegration-selected absence.
// - Detect and clear interrupts gated by masks.
// - Source select bit chooses register for overhead.
// - Written byte sent least significant bit first.
// - Buffer-empty flag sets after byte sent.
// - Buffer-empty interrupt gated by its mask.
// - Without new write, previous byte is resent.
// - Transmit bytes sent raw, no zero stuffing.
// - Superframe mode sends only low six bits.
// - Received bits shift in, first bit lowest.
// - Receive-full flag sets when byte filled.
// - Receive-full interrupt gated by its mask.
// - Receive bits delivered raw, no destuffing.
// - Superframe receive updates on multiframe boundaries.
`default_nettype none

package fdl_pkg;

  // ==========================================================================
  // Register map.
  localparam int             ADDR_W          = 9;
  localparam logic [8:0]     OFS_RX_CODE_CTL = 9'h015;
  localparam logic [8:0]     OFS_RX_LINK     = 9'h062;
  localparam logic [8:0]     OFS_RX_CODE_VAL = 9'h063;
  localparam logic [8:0]     OFS_RX_STAT7    = 9'h096;
  localparam logic [8:0]     OFS_RX_MASK7    = 9'h0A6;
  localparam logic [8:0]     OFS_TX_LINK     = 9'h162;
  localparam logic [8:0]     OFS_TX_CTL2     = 9'h182;
  localparam logic [8:0]     OFS_TX_STAT2    = 9'h191;
  localparam logic [8:0]     OFS_TX_MASK2    = 9'h1A1;
  localparam logic [7:0]     RST_BYTE        = 8'h00;

  // ==========================================================================
  // Field positions.
  localparam int             CC_FILT_LSB     = 0;
  localparam int             CC_DIS_LSB      = 2;
  localparam int             ST7_DETECT      = 0;
  localparam int             ST7_CLEAR       = 1;
  localparam int             ST7_FULL        = 2;
  localparam int             ST2_EMPTY       = 4;
  localparam int             CTL2_SRC        = 7;

  // ==========================================================================
  // Link framing counts.
  localparam logic [2:0]     TX_LAST_ESF     = 3'h7;
  localparam logic [2:0]     TX_LAST_D4      = 3'h5;
  localparam logic [2:0]     RX_LAST_BIT     = 3'h7;
  localparam logic [3:0]     CODE_SLOT_LAST  = 4'hF;
  localparam logic [5:0]     REP_MAX         = 6'h3F;

  typedef enum logic {
    BOC_IDLE = 1'b0,
    BOC_HELD = 1'b1
  } fdl_boc_st_t;

  // Receive side strobes from the framer.
  typedef struct packed {
    logic bit_stb;
    logic bit_val;
    logic mf_bound;
  } fdl_rx_in_t;

  // Transmit overhead bit handed to the framer.
  typedef struct packed {
    logic from_reg;
    logic bit_val;
  } fdl_tx_out_t;

endpackage

`default_nettype wire

// ===== bench/fdl_frm_model.sv
`default_nettype none

// ============================================================================
// Framer side model: serialises a word of overhead bits, one every 4 cycles.
module fdl_frm_model
  import fdl_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        go,
  input  wire logic [15:0] word,
  input  wire logic [4:0]  nbits,
  input  wire logic        mf_req,
  output wire fdl_rx_in_t  rx_in,
  output wire logic        tx_slot,
  output wire logic        busy
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [15:0] sh_r;
  logic [4:0]  left_r;
  logic [1:0]  gap_r;
  logic        last_r;
  logic        stb;

  // Bit timer and shifter; the first bit sent is word bit 0.
  always_ff @(posedge mclk) begin
    if (rst) begin
      sh_r   <= 16'h0000;
      left_r <= 5'h00;
      gap_r  <= 2'h0;
      last_r <= 1'b0;
    end else if (go) begin
      sh_r   <= word;
      left_r <= nbits;
      gap_r  <= 2'h0;
    end else if (left_r != 5'h00) begin
      gap_r <= gap_r + 2'h1;
      if (gap_r == 2'h3) begin
        sh_r   <= sh_r >> 1;
        left_r <= left_r - 5'h01;
        last_r <= sh_r[0];
      end
    end
  end

  // Between strobes the data line shows the inverse of the last bit.
  assign stb     = (left_r != 5'h00) && (gap_r == 2'h3);
  assign rx_in   = {stb, stb ? sh_r[0] : ~last_r, mf_req};
  assign tx_slot = stb;
  assign busy    = (left_r != 5'h00) || go;
endmodule

`default_nettype wire

// ===== bench/t1_facility_data_link_bench.sv
`default_nettype none

module t1_facility_data_link_bench
  import fdl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic              mclk, rst, wr, rd, esf_mode, tx_slot, busy;
  logic              go, mf_req, slot_d, irq_n;
  logic [ADDR_W-1:0] addr;
  logic [7:0]        wdata, rdata;
  logic [15:0]       word, tx_seen;
  logic [4:0]        nbits;
  fdl_rx_in_t        rx_in;
  fdl_tx_out_t       tx_out;
  int                failures, total_checks;

  fdl_top uut (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .esf_mode(esf_mode), .rx_in(rx_in),
    .tx_slot(tx_slot), .tx_out(tx_out), .interrupt_out_n(irq_n));

  fdl_frm_model frm (.mclk(mclk), .rst(rst), .go(go), .word(word),
    .nbits(nbits), .mf_req(mf_req), .rx_in(rx_in), .tx_slot(tx_slot),
    .busy(busy));

  // ==========================================================================
  // Clock, and capture of each transmitted bit the cycle after its slot.
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    if (rst) begin
      slot_d  <= 1'b0;
      tx_seen <= 16'h0000;
    end else begin
      slot_d <= tx_slot;
      if (slot_d) begin
        tx_seen <= {tx_out.bit_val, tx_seen[15:1]};
      end
    end
  end

  // ==========================================================================
  // Comparison, verdict and bus tasks.
  task automatic check(input string nm, input logic [15:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic wr_reg(input logic [8:0] a, input logic [7:0] d);
    @(posedge mclk) begin wr <= 1'b1; addr <= a; wdata <= d; end
    @(posedge mclk) wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [8:0] a, input logic [7:0] e);
    @(posedge mclk) begin rd <= 1'b1; addr <= a; end
    @(posedge mclk) rd <= 1'b0;
    #1 check($sformatf("reg %h", a), {8'h00, rdata}, {8'h00, e});
  endtask

  task automatic irq_chk(input logic e);
    repeat (2) @(posedge mclk);
    #1 check("interrupt", {15'h0000, irq_n}, {15'h0000, e});
  endtask

  // Sends n bits of w through the framer model and waits for the last one.
  task automatic send(input logic [15:0] w, input logic [4:0] n);
    @(posedge mclk) begin go <= 1'b1; word <= w; nbits <= n; end
    @(posedge mclk) go <= 1'b0;
    repeat (100) begin
      @(posedge mclk);
      if (!busy) break;
    end
    repeat (3) @(posedge mclk);
  endtask

  // ==========================================================================
  // Scenarios.
  task automatic t_regs();
    logic [8:0] ofs [10] = '{OFS_RX_CODE_CTL, OFS_RX_LINK, OFS_RX_CODE_VAL,
      OFS_RX_STAT7, OFS_RX_MASK7, OFS_TX_LINK, OFS_TX_CTL2, OFS_TX_STAT2,
      OFS_TX_MASK2, 9'h100};
    foreach (ofs[i]) rd_chk(ofs[i], RST_BYTE);
    wr_reg(OFS_RX_LINK, 8'h5A);
    rd_chk(OFS_RX_LINK, 8'h00);
    wr_reg(9'h100, 8'hFF);
    rd_chk(9'h100, 8'h00);
    check("from_reg", {15'h0000, tx_out.from_reg}, 16'h0001);
  endtask

  task automatic t_rx_esf();
    wr_reg(OFS_TX_LINK, 8'hA5);
    wr_reg(OFS_RX_MASK7, 8'h04);
    send(16'h003C, 5'd8);
    check("first tx byte", tx_seen[15:8], 16'h0000);
    rd_chk(OFS_RX_LINK, 8'h3C);
    rd_chk(OFS_RX_STAT7, 8'h04);
    rd_chk(OFS_TX_STAT2, 8'h10);
    irq_chk(1'b0);
    wr_reg(OFS_RX_STAT7, 8'h04);
    wr_reg(OFS_TX_STAT2, 8'h10);
    irq_chk(1'b1);
  endtask

  task automatic t_tx_esf();
    wr_reg(OFS_RX_MASK7, 8'h00);
    wr_reg(OFS_TX_MASK2, 8'h10);
    send(16'h0000, 5'd16);
    check("tx bytes raw", tx_seen, 16'hA5A5);
    irq_chk(1'b0);
    wr_reg(OFS_TX_STAT2, 8'h10);
    irq_chk(1'b1);
    wr_reg(OFS_TX_MASK2, 8'h00);
  endtask

  task automatic t_d4();
    @(posedge mclk) esf_mode <= 1'b0;
    wr_reg(OFS_TX_LINK, 8'hDC);
    send(16'h0B2D, 5'd12);
    check("d4 tx bits", {4'h0, tx_seen[15:4]}, 16'h0725);
    @(posedge mclk) mf_req <= 1'b1;
    @(posedge mclk) mf_req <= 1'b0;
    rd_chk(OFS_RX_LINK, 8'h2C);
    wr_reg(OFS_RX_STAT7, 8'hFF);
    repeat (3) send(16'h1AFF, 5'd16);
    rd_chk(OFS_RX_STAT7, 8'h00);
    wr_reg(OFS_TX_CTL2, 8'h80);
    @(posedge mclk) #1 check("src sel", {15'h0, tx_out.from_reg}, 16'h0);
    send(16'h0000, 5'd8);
    check("slot ignored", tx_seen[15:8], 16'h0000);
    wr_reg(OFS_TX_CTL2, 8'h00);
  endtask

  task automatic t_boc();
    @(posedge mclk) esf_mode <= 1'b1;
    wr_reg(OFS_RX_CODE_CTL, 8'h00);
    wr_reg(OFS_RX_MASK7, 8'h03);
    wr_reg(OFS_RX_STAT7, 8'hFF);
    repeat (2) send(16'h1AFF, 5'd16);
    rd_chk(OFS_RX_STAT7, 8'h04);
    send(16'h1AFF, 5'd16);
    rd_chk(OFS_RX_STAT7, 8'h05);
    rd_chk(OFS_RX_CODE_VAL, 8'h0D);
    irq_chk(1'b0);
    wr_reg(OFS_RX_STAT7, 8'h01);
    irq_chk(1'b1);
    repeat (2) send(16'h1AFF, 5'd16);
    rd_chk(OFS_RX_STAT7, 8'h04);
    repeat (4) send(16'hFFFF, 5'd16);
    rd_chk(OFS_RX_STAT7, 8'h06);
    wr_reg(OFS_RX_STAT7, 8'hFF);
    repeat (3) send(16'h1AFF, 5'd16);
    rd_chk(OFS_RX_STAT7, 8'h05);
  endtask

  // ==========================================================================
  // Main sequence and watchdog.
  initial begin
    failures = 0;
    total_checks = 0;
    rst = 1'b1;
    {wr, rd, go, mf_req} = 4'h0;
    addr = 9'h000;
    wdata = 8'h00;
    word = 16'h0000;
    nbits = 5'h00;
    esf_mode = 1'b1;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    t_regs();
    t_rx_esf();
    t_tx_esf();
    t_d4();
    t_boc();
    stop_test();
  end

  initial begin
    #200000;
    failures++;
    stop_test();
  end
endmodule

`default_nettype wire
